// File: cbbs_pkg.sv
// Shared constants and types for the branch and bit-set execute block.
package cbbs_pkg;

    // ----------------------------------------
    // Instruction word layout
    // ----------------------------------------
    localparam int INSTR_W  = 24;
    localparam int PC_W     = 24;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 13;
    localparam int POS_W    = 4;
    localparam int OPC_HI   = 23;
    localparam int OPC_LO   = 16;
    localparam int OFF_HI   = 15;
    localparam int OFF_LO   = 0;
    localparam int POS_HI_H = 15;   // Upper three position bits.
    localparam int POS_HI_L = 13;
    localparam int POS_LO   = 0;    // Lowest position bit.
    localparam int FADR_HI  = 12;   // Word address bits 12..1.
    localparam int FADR_LO  = 1;

    // ----------------------------------------
    // Opcode upper bytes
    // ----------------------------------------
    localparam logic [7:0] OPC_JUMP_SAT_A = 8'h0E;
    localparam logic [7:0] OPC_JUMP_SAT_B = 8'h0F;
    localparam logic [7:0] OPC_JUMP_ZERO  = 8'h32;
    localparam logic [7:0] OPC_BIT_FORCE  = 8'hA8;

    // ----------------------------------------
    // Arithmetic and timing constants
    // ----------------------------------------
    localparam logic [PC_W-1:0]   PC_STEP      = 24'h00_0002;
    localparam logic              ADDR_EVEN    = 1'b0;
    localparam logic              OFF_SCALE_LO = 1'b0;
    localparam int                SEXT_W       = PC_W - 17;
    localparam int                CYC_NOT_TAKEN = 1;
    localparam int                CYC_TAKEN_BASIC = 2;
    localparam int                CYC_TAKEN_ENH = 4;
    localparam int                CYC_BIT_FORCE = 1;
    localparam logic [1:0]        NOP_LEFT_BASIC =
        2'(CYC_TAKEN_BASIC - CYC_NOT_TAKEN - 1);
    localparam logic [1:0]        NOP_LEFT_ENH =
        2'(CYC_TAKEN_ENH - CYC_NOT_TAKEN - 1);
    localparam logic [1:0]        CNT_ZERO     = 2'h0;
    localparam logic [1:0]        CNT_ONE      = 2'h1;
    localparam logic [PC_W-1:0]   PC_RESET     = 24'h00_0000;
    localparam logic [DATA_W-1:0] DATA_RESET   = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET   = 13'h0000;
    localparam logic [POS_W-1:0]  POS_RESET    = 4'h0;

    // ----------------------------------------
    // Execute state
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_RMW    = 2'b01,
        ST_BRWAIT = 2'b10
    } cbbs_state_t;

endpackage

// File: cbbs_decode.sv
// Opcode decoder for the branch and bit-set instructions.
`timescale 1ns/1ns
module cbbs_decode
    import cbbs_pkg::*;
(
    input  wire logic [cbbs_pkg::INSTR_W-1:0] instrWord,
    output logic                              isJumpSatA,
    output logic                              isJumpSatB,
    output logic                              isJumpZero,
    output logic                              isBitForce,
    output logic [15:0]                       signedWordOffset,
    output logic [cbbs_pkg::POS_W-1:0]        bitPositionField,
    output logic [cbbs_pkg::ADDR_W-1:0]       wordAddr
);
    import cbbs_pkg::*;

    logic [7:0] opcUpper;

    // ----------------------------------------
    // Opcode match
    // ----------------------------------------
    // Upper byte selects one of the four instructions.
    always_comb begin
        opcUpper   = instrWord[OPC_HI:OPC_LO];
        // RULE1: match saturation A.
        isJumpSatA = (opcUpper == OPC_JUMP_SAT_A);
        // RULE2: match saturation B.
        // RULE15: assumed second nibble.
        isJumpSatB = (opcUpper == OPC_JUMP_SAT_B);
        // RULE3: match zero jump.
        isJumpZero = (opcUpper == OPC_JUMP_ZERO);
        // RULE8: match bit force.
        isBitForce = (opcUpper == OPC_BIT_FORCE);
    end

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    // RULE5: signed instruction count.
    assign signedWordOffset = instrWord[OFF_HI:OFF_LO];
    // RULE9: split b and f fields.
    assign bitPositionField = {instrWord[POS_HI_H:POS_HI_L], instrWord[POS_LO]};
    // RULE10: word-aligned address.
    assign wordAddr = {instrWord[FADR_HI:FADR_LO], ADDR_EVEN};

endmodule

// File: cbbs_bitset.sv
// Forces one selected bit of a data word to one.
`timescale 1ns/1ns
module cbbs_bitset
    import cbbs_pkg::*;
(
    input  wire logic [cbbs_pkg::DATA_W-1:0] dataIn,
    input  wire logic [cbbs_pkg::POS_W-1:0]  bitPos,
    output logic [cbbs_pkg::DATA_W-1:0]      dataOut
);
    import cbbs_pkg::*;

    // ----------------------------------------
    // Per-bit merge
    // ----------------------------------------
    // RULE8: only the chosen bit set.
    // RULE11: bit 0 is least significant.
    for (genvar i = 0; i < DATA_W; i++) begin : gBit
        assign dataOut[i] = dataIn[i] | (bitPos == POS_W'(i));
    end

endmodule

// File: cbbs_exec.sv
// Execute stage for three conditional jumps and a memory bit force.
//
// Contract
// RULE1: The saturation-A jump, upper byte 0x0E, redirects only when the A saturation flag is one.
// RULE2: The saturation-B jump, opcode starting 0000, is taken only when the B saturation flag is one.
// RULE3: The zero jump, upper byte 0x32, is taken only when the zero flag is one.
// RULE4: A taken jump loads PC plus two plus twice the sign-extended 16-bit offset.
// RULE5: The low sixteen opcode bits are a signed instruction count from the next address.
// RULE6: A taken jump turns the already fetched next instruction into a no-operation.
// RULE7: A jump not taken takes one cycle; taken it takes two, or four on enhanced cores.
// RULE8: The bit force, upper byte 0xA8, sets the chosen memory bit and keeps all others.
// RULE9: The position comes from the b bits and the 13-bit address from the f bits.
// RULE10: Addresses span 0 to 8191 for bytes and even 0 to 8190 for words.
// RULE11: Bits count from 0 at the bottom up to 7 for bytes or 15 for words.
// RULE12: The byte suffix selects 8-bit work; word size is the default. This block implements word size only.
// RULE13: The bit force issues in one cycle; enhanced peripheral accesses may stretch it.
// RULE14: None of these instructions changes any status flag.
// RULE15: The second nibble of the saturation-B opcode is taken as 1111.
`timescale 1ns/1ns
module cbbs_exec
    import cbbs_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic                         rst_b,
    input  wire logic                         coreEnhanced,
    input  wire logic                         instrValid,
    input  wire logic [cbbs_pkg::INSTR_W-1:0] instrWord,
    input  wire logic [cbbs_pkg::PC_W-1:0]    instrPc,
    input  wire logic                         accASaturatedFlag,
    input  wire logic                         accBSaturatedFlag,
    input  wire logic                         zeroFlag,
    input  wire logic [cbbs_pkg::DATA_W-1:0]  memRdData,
    input  wire logic                         memReady,
    output logic                              instrReady,
    output logic                              pcLoad,
    output logic [cbbs_pkg::PC_W-1:0]         pcTarget,
    output logic                              squashNext,
    output logic                              memRdEn,
    output logic [cbbs_pkg::ADDR_W-1:0]       memAddr,
    output logic                              memWrEn,
    output logic [cbbs_pkg::ADDR_W-1:0]       memWrAddr,
    output logic [cbbs_pkg::DATA_W-1:0]       memWrData,
    output logic                              flagWrEn
);
    import cbbs_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    cbbs_state_t             state_reg;
    cbbs_state_t             state_next;
    logic [1:0]              nopCnt_reg;
    logic [1:0]              nopCnt_next;
    logic                    ready_reg;
    logic                    ready_next;
    logic                    pcLoad_reg;
    logic                    pcLoad_next;
    logic [PC_W-1:0]         pcTarget_reg;
    logic [PC_W-1:0]         pcTarget_next;
    logic                    squash_reg;
    logic                    squash_next;
    logic                    rdEn_reg;
    logic                    rdEn_next;
    logic [ADDR_W-1:0]       rdAddr_reg;
    logic [ADDR_W-1:0]       rdAddr_next;
    logic [POS_W-1:0]        bitPos_reg;
    logic [POS_W-1:0]        bitPos_next;
    logic                    wrEn_reg;
    logic                    wrEn_next;
    logic [ADDR_W-1:0]       wrAddr_reg;
    logic [ADDR_W-1:0]       wrAddr_next;
    logic [DATA_W-1:0]       wrData_reg;
    logic [DATA_W-1:0]       wrData_next;
    logic                    flagWr_reg;
    logic                    flagWr_next;

    logic                    isJumpSatA;
    logic                    isJumpSatB;
    logic                    isJumpZero;
    logic                    isBitForce;
    logic [15:0]             signedWordOffset;
    logic [POS_W-1:0]        bitPositionField;
    logic [ADDR_W-1:0]       wordAddr;
    logic                    isJump;
    logic                    jumpTaken;
    logic [PC_W-1:0]         relativeJump;
    logic                    canIssue;
    logic                    fwdHit;
    logic [DATA_W-1:0]       rmwSource;
    logic [DATA_W-1:0]       rmwResult;

    // ----------------------------------------
    // Submodules
    // ----------------------------------------
    // Decodes the presented instruction word.
    cbbs_decode uDecode (
        .instrWord        (instrWord),
        .isJumpSatA       (isJumpSatA),
        .isJumpSatB       (isJumpSatB),
        .isJumpZero       (isJumpZero),
        .isBitForce       (isBitForce),
        .signedWordOffset (signedWordOffset),
        .bitPositionField (bitPositionField),
        .wordAddr         (wordAddr)
    );

    // Merges the forced bit into the fetched word.
    cbbs_bitset uBitset (
        .dataIn  (rmwSource),
        .bitPos  (bitPos_reg),
        .dataOut (rmwResult)
    );

    // ----------------------------------------
    // Jump condition and target
    // ----------------------------------------
    // Selects the flag that the decoded jump tests.
    always_comb begin
        isJump    = isJumpSatA | isJumpSatB | isJumpZero;
        // RULE1: taken on A saturation.
        // RULE2: taken on B saturation.
        // RULE3: taken on zero flag.
        jumpTaken = (isJumpSatA & accASaturatedFlag)
                  | (isJumpSatB & accBSaturatedFlag)
                  | (isJumpZero & zeroFlag);
        // RULE4: next PC plus doubled offset.
        // RULE5: offset sign-extended first.
        relativeJump = instrPc + PC_STEP
                     + {{SEXT_W{signedWordOffset[15]}}, signedWordOffset, OFF_SCALE_LO};
    end

    // ----------------------------------------
    // Read data forwarding
    // ----------------------------------------
    // A write still leaving for the same word replaces stale read data.
    always_comb begin
        fwdHit    = wrEn_reg & (wrAddr_reg == rdAddr_reg);
        rmwSource = fwdHit ? wrData_reg : memRdData;
    end

    // An instruction is taken only while the stage has room for it.
    assign canIssue = instrValid & ready_reg
                    & ((state_reg == ST_IDLE) | ((state_reg == ST_RMW) & memReady));

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Completes the running operation, then issues a new one if offered.
    always_comb begin
        state_next    = state_reg;
        nopCnt_next   = nopCnt_reg;
        ready_next    = ready_reg;
        pcLoad_next   = 1'b0;
        pcTarget_next = pcTarget_reg;
        squash_next   = 1'b0;
        rdEn_next     = rdEn_reg;
        rdAddr_next   = rdAddr_reg;
        bitPos_next   = bitPos_reg;
        wrEn_next     = 1'b0;
        wrAddr_next   = wrAddr_reg;
        wrData_next   = wrData_reg;
        // RULE14: flags never written.
        flagWr_next   = 1'b0;

        case (state_reg)
            ST_IDLE: begin
                ready_next = 1'b1;
            end
            ST_RMW: begin
                // RULE13: write back after read.
                if (memReady) begin
                    wrEn_next   = 1'b1;
                    wrAddr_next = rdAddr_reg;
                    wrData_next = rmwResult;
                    rdEn_next   = 1'b0;
                    state_next  = ST_IDLE;
                end
            end
            ST_BRWAIT: begin
                // RULE7: hold fetch for taken cycles.
                if (nopCnt_reg == CNT_ZERO) begin
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    nopCnt_next = nopCnt_reg - CNT_ONE;
                end
            end
            default: begin
                ready_next = 1'b1;
                rdEn_next  = 1'b0;
                state_next = ST_IDLE;
            end
        endcase

        if (canIssue) begin
            if (isJump && jumpTaken) begin
                // RULE4: load the jump target.
                pcLoad_next   = 1'b1;
                pcTarget_next = relativeJump;
                // RULE6: fetched word becomes NOP.
                squash_next   = 1'b1;
                ready_next    = 1'b0;
                // RULE7: two or four cycles.
                nopCnt_next   = coreEnhanced ? NOP_LEFT_ENH : NOP_LEFT_BASIC;
                state_next    = ST_BRWAIT;
            end else if (isBitForce) begin
                // RULE9: latch address and position.
                // RULE12: always a word access; no byte lane select.
                rdEn_next   = 1'b1;
                rdAddr_next = wordAddr;
                bitPos_next = bitPositionField;
                state_next  = ST_RMW;
            end
            // A jump not taken, or any other opcode, just retires.
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // Registers every next value; reset clears all control state.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg    <= ST_IDLE;
            nopCnt_reg   <= CNT_ZERO;
            ready_reg    <= 1'b0;
            pcLoad_reg   <= 1'b0;
            pcTarget_reg <= PC_RESET;
            squash_reg   <= 1'b0;
            rdEn_reg     <= 1'b0;
            rdAddr_reg   <= ADDR_RESET;
            bitPos_reg   <= POS_RESET;
            wrEn_reg     <= 1'b0;
            wrAddr_reg   <= ADDR_RESET;
            wrData_reg   <= DATA_RESET;
            flagWr_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            nopCnt_reg   <= nopCnt_next;
            ready_reg    <= ready_next;
            pcLoad_reg   <= pcLoad_next;
            pcTarget_reg <= pcTarget_next;
            squash_reg   <= squash_next;
            rdEn_reg     <= rdEn_next;
            rdAddr_reg   <= rdAddr_next;
            bitPos_reg   <= bitPos_next;
            wrEn_reg     <= wrEn_next;
            wrAddr_reg   <= wrAddr_next;
            wrData_reg   <= wrData_next;
            flagWr_reg   <= flagWr_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a flip-flop.
    assign instrReady = ready_reg;
    assign pcLoad     = pcLoad_reg;
    assign pcTarget   = pcTarget_reg;
    assign squashNext = squash_reg;
    assign memRdEn    = rdEn_reg;
    assign memAddr    = rdAddr_reg;
    assign memWrEn    = wrEn_reg;
    assign memWrAddr  = wrAddr_reg;
    assign memWrData  = wrData_reg;
    assign flagWrEn   = flagWr_reg;

endmodule

// File: cbbs_exec_chk.sv
// Concurrent checks on the ports of the branch and bit-set execute block.
`timescale 1ns/1ns
module cbbs_exec_chk
    import cbbs_pkg::*;
(
    input wire logic                         mclk,
    input wire logic                         rst_b,
    input wire logic                         coreEnhanced,
    input wire logic                         instrValid,
    input wire logic [cbbs_pkg::INSTR_W-1:0] instrWord,
    input wire logic [cbbs_pkg::PC_W-1:0]    instrPc,
    input wire logic                         accASaturatedFlag,
    input wire logic                         accBSaturatedFlag,
    input wire logic                         zeroFlag,
    input wire logic [cbbs_pkg::DATA_W-1:0]  memRdData,
    input wire logic                         memReady,
    input wire logic                         instrReady,
    input wire logic                         pcLoad,
    input wire logic [cbbs_pkg::PC_W-1:0]    pcTarget,
    input wire logic                         squashNext,
    input wire logic                         memRdEn,
    input wire logic [cbbs_pkg::ADDR_W-1:0]  memAddr,
    input wire logic                         memWrEn,
    input wire logic [cbbs_pkg::ADDR_W-1:0]  memWrAddr,
    input wire logic [cbbs_pkg::DATA_W-1:0]  memWrData,
    input wire logic                         flagWrEn
);
    import cbbs_pkg::*;

    default clocking chkClk @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic              take;
    logic              isForce;
    logic              jumpCond;
    logic [PC_W-1:0]   targetExp;
    logic [DATA_W-1:0] forceVal;
    logic [POS_W-1:0]  pos_reg;
    logic [POS_W-1:0]  pos_next;

    // Acceptance, jump condition, expected target and expected forced word.
    always_comb begin
        take      = instrValid && instrReady && (!memRdEn || memReady);
        isForce   = instrWord[OPC_HI:OPC_LO] == OPC_BIT_FORCE;
        jumpCond  = (instrWord[OPC_HI:OPC_LO] == OPC_JUMP_SAT_A && accASaturatedFlag)
                 || (instrWord[OPC_HI:OPC_LO] == OPC_JUMP_SAT_B && accBSaturatedFlag)
                 || (instrWord[OPC_HI:OPC_LO] == OPC_JUMP_ZERO && zeroFlag);
        targetExp = instrPc + PC_STEP + PC_W'(2 * $signed(instrWord[OFF_HI:OFF_LO]));
        forceVal  = ((memWrEn && memWrAddr == memAddr) ? memWrData : memRdData)
                  | (16'h0001 << pos_reg);
        pos_next  = (take && isForce) ? {instrWord[POS_HI_H:POS_HI_L], instrWord[POS_LO]}
                                      : pos_reg;
    end

    // Holds the position of the bit force whose read is outstanding.
    always_ff @(posedge mclk) begin
        pos_reg <= rst_b ? pos_next : POS_RESET;
    end

    sequence jumpTaken_s;
        take && jumpCond;
    endsequence
    sequence forceTaken_s;
        take && isForce;
    endsequence
    sequence readDone_s;
        memRdEn && memReady;
    endsequence

    jump_taken_a: assert property (
        jumpTaken_s |=> pcLoad && squashNext) else $error("taken jump gave no redirect");
    jump_skip_a: assert property (
        take && !jumpCond |=> !pcLoad && !squashNext) else $error("redirect without cause");
    jump_target_a: assert property (
        jumpTaken_s |=> pcTarget == $past(targetExp)) else $error("wrong jump target");
    nop_once_a: assert property (
        pcLoad |-> squashNext ##1 !(pcLoad || squashNext)) else $error("squash pulse wrong");
    stall_basic_a: assert property (
        jumpTaken_s ##0 !coreEnhanced |=> !instrReady ##1 instrReady)
        else $error("basic taken jump length wrong");
    stall_enh_a: assert property (
        jumpTaken_s ##0 coreEnhanced |=> !instrReady [*3] ##1 instrReady)
        else $error("enhanced taken jump length wrong");
    force_read_a: assert property (
        forceTaken_s |=> memRdEn && memAddr == {$past(instrWord[FADR_HI:FADR_LO]), ADDR_EVEN})
        else $error("bit force read wrong");
    force_write_a: assert property (
        readDone_s |=> memWrEn && memWrAddr == $past(memAddr) && memWrData == $past(forceVal))
        else $error("bit force write wrong");
    flags_kept_a: assert property (
        take |=> !flagWrEn ##1 !flagWrEn) else $error("status flags written");
endmodule

bind cbbs_exec cbbs_exec_chk chk_u (
    .mclk, .rst_b, .coreEnhanced, .instrValid, .instrWord, .instrPc, .accASaturatedFlag,
    .accBSaturatedFlag, .zeroFlag, .memRdData, .memReady, .instrReady, .pcLoad, .pcTarget,
    .squashNext, .memRdEn, .memAddr, .memWrEn, .memWrAddr, .memWrData, .flagWrEn
);

// File: cbbs_mem_model.sv
// Behavioural data memory that answers the block's read-modify-write port.
`timescale 1ns/1ns
module cbbs_mem_model
    import cbbs_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        rst_b,
    input  wire logic                        slowMode,
    input  wire logic                        memRdEn,
    input  wire logic [cbbs_pkg::ADDR_W-1:0] memAddr,
    input  wire logic                        memWrEn,
    input  wire logic [cbbs_pkg::ADDR_W-1:0] memWrAddr,
    input  wire logic [cbbs_pkg::DATA_W-1:0] memWrData,
    output logic      [cbbs_pkg::DATA_W-1:0] memRdData,
    output logic                             memReady
);
    import cbbs_pkg::*;
    logic [DATA_W-1:0] memArr [4096];
    logic [1:0]        wait_reg;
    logic [1:0]        wait_next;
    logic [DATA_W-1:0] last_reg;
    logic [DATA_W-1:0] last_next;

    // Fills every word with a distinct pattern.
    initial begin
        for (int i = 0; i < 4096; i++) begin
            memArr[i] = DATA_W'(i * 16'h0137) ^ 16'h5A3C;
        end
    end

    // slow word access
    // Slow mode stretches each read by two cycles; idle data never repeats the last word.
    always_comb begin
        memReady  = memRdEn && (!slowMode || wait_reg == 2'h2);
        memRdData = memReady ? memArr[memAddr[ADDR_W-1:1]] : ~last_reg;
        wait_next = (memRdEn && !memReady) ? wait_reg + 2'h1 : 2'h0;
        last_next = memRdData;
    end

    // Registers the wait count and the last driven data, and lands writes.
    always @(posedge mclk) begin
        wait_reg <= rst_b ? wait_next : 2'h0;
        last_reg <= rst_b ? last_next : 16'hA5A5;
        if (memWrEn) begin
            memArr[memWrAddr[ADDR_W-1:1]] <= memWrData;
        end
    end
endmodule

// File: cond_branch_bit_set_exec_test.sv
// Self-checking bench for the branch and bit-set execute block.
`timescale 1ns/1ns
module cond_branch_bit_set_exec_test;
    import cbbs_pkg::*;

    logic               mclk              = 1'h0;
    logic               rst_b             = 1'h0;
    logic               coreEnhanced      = 1'h0;
    logic               instrValid        = 1'h0;
    logic [INSTR_W-1:0] instrWord         = 24'h00_0000;
    logic [PC_W-1:0]    instrPc           = 24'h00_0000;
    logic               accASaturatedFlag = 1'h0;
    logic               accBSaturatedFlag = 1'h0;
    logic               zeroFlag          = 1'h0;
    logic               slowMode          = 1'h0;
    logic [DATA_W-1:0]  memRdData;
    logic               memReady;
    logic               instrReady;
    logic               pcLoad;
    logic [PC_W-1:0]    pcTarget;
    logic               squashNext;
    logic               memRdEn;
    logic [ADDR_W-1:0]  memAddr;
    logic               memWrEn;
    logic [ADDR_W-1:0]  memWrAddr;
    logic [DATA_W-1:0]  memWrData;
    logic               flagWrEn;
    int                 errors            = 0;
    int                 n_tests           = 0;
    int                 lastWait;
    logic [DATA_W-1:0]  shadow [logic [ADDR_W-1:0]];
    logic [28:0]        expQ [$];
    logic [28:0]        wrExp;
    logic [7:0]         opcs [3]          = '{OPC_JUMP_SAT_A, OPC_JUMP_SAT_B, OPC_JUMP_ZERO};

    cbbs_exec dut_u (
        .mclk, .rst_b, .coreEnhanced, .instrValid, .instrWord, .instrPc, .accASaturatedFlag,
        .accBSaturatedFlag, .zeroFlag, .memRdData, .memReady, .instrReady, .pcLoad,
        .pcTarget, .squashNext, .memRdEn, .memAddr, .memWrEn, .memWrAddr, .memWrData,
        .flagWrEn
    );
    cbbs_mem_model mem_u (
        .mclk, .rst_b, .slowMode, .memRdEn, .memAddr, .memWrEn, .memWrAddr, .memWrData,
        .memRdData, .memReady
    );

    // Core clock of 40 ns.
    always #20 mclk = ~mclk;

    task automatic check(input string what, input logic [23:0] expv, input logic [23:0] got);
        n_tests++;
        if (got !== expv) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Presents a word and holds it until the edge that takes it.
    task automatic issue(input logic [INSTR_W-1:0] word, input logic [PC_W-1:0] pc);
        instrWord  = word;
        instrPc    = pc;
        instrValid = 1'h1;
        for (lastWait = 0; lastWait < 16; lastWait++) begin
            @(negedge mclk);
            if (instrReady === 1'h1 && (memRdEn === 1'h0 || memReady === 1'h1)) begin
                break;
            end
        end
        check("instruction taken", 24'h00_0001, 24'(lastWait < 16));
        @(posedge mclk);
        #1;
    endtask

    // One jump with its own flag set or clear and every other flag opposite.
    task automatic jump_case(input logic [7:0] opc, input logic flagOn, input logic enh,
                             input logic [15:0] off);
        int lowCnt;
        int lowExp;
        lowExp            = flagOn ? (enh ? 4 : 2) - 1 : 0;
        coreEnhanced      = enh;
        accASaturatedFlag = (opc == OPC_JUMP_SAT_A) ? flagOn : !flagOn;
        accBSaturatedFlag = (opc == OPC_JUMP_SAT_B) ? flagOn : !flagOn;
        zeroFlag          = (opc == OPC_JUMP_ZERO) ? flagOn : !flagOn;
        issue({opc, off}, 24'h00_2000);
        instrValid = 1'h0;
        check("redirect", 24'(flagOn), 24'(pcLoad));
        check("squash", 24'(flagOn), 24'(squashNext));
        check("flag write", 24'h00_0000, 24'(flagWrEn));
        if (flagOn) begin
            check("target", 24'h00_2002 + 24'(2 * $signed(off)), pcTarget);
        end
        for (lowCnt = 0; instrReady !== 1'h1 && lowCnt < 8; lowCnt++) begin
            @(posedge mclk);
            #1;
        end
        check("refused cycles", 24'(lowExp), 24'(lowCnt));
    endtask

    // Issues a bit force on an even word address and records the expected write.
    task automatic force_bit(input logic [ADDR_W-1:0] addr, input logic [POS_W-1:0] pos);
        logic [DATA_W-1:0] oldVal;
        oldVal       = shadow.exists(addr) ? shadow[addr] : mem_u.memArr[addr[ADDR_W-1:1]];
        shadow[addr] = oldVal | (16'h0001 << pos);
        expQ.push_back({addr, shadow[addr]});
        issue({OPC_BIT_FORCE, pos[3:1], addr[12:1], pos[0]}, 24'h00_0100);
    endtask

    // Compares each write pulse against the oldest expected write.
    always @(negedge mclk) begin
        if (memWrEn === 1'h1 && expQ.size() > 0) begin
            wrExp = expQ.pop_front();
            check("write address", 24'(wrExp[28:16]), 24'(memWrAddr));
            check("write data", 24'(wrExp[15:0]), 24'(memWrData));
        end else if (memWrEn === 1'h1) begin
            check("unexpected write", 24'h00_0000, 24'h00_0001);
        end
    end

    // Cuts a hang short.
    initial begin
        #(40 * 3000);
        errors++;
        conclude();
    end

    // Reset, all jump cases, then pipelined and stalled bit forces.
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        rst_b = 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        check("ready after reset", 24'h00_0001, 24'(instrReady));
        foreach (opcs[i]) begin
            for (int f = 0; f < 2; f++) begin
                for (int e = 0; e < 2; e++) begin
                    jump_case(opcs[i], f[0], e[0], (f == e) ? 16'h8000 : 16'h7FFF);
                end
            end
        end
        jump_case(8'h3A, 1'h0, 1'h0, 16'h0004);
        zeroFlag = 1'h0;
        issue({OPC_JUMP_ZERO, 16'h0005}, 24'h00_2000);
        force_bit(13'h1FFE, 4'hF);
        check("wait after skipped jump", 24'h00_0000, 24'(lastWait));
        force_bit(13'h1FFE, 4'h0);
        force_bit(13'h0000, 4'h7);
        slowMode = 1'h1;
        force_bit(13'h0600, 4'hB);
        force_bit(13'h0600, 4'h3);
        force_bit(13'h0444, 4'hF);
        instrValid = 1'h0;
        repeat (6) @(posedge mclk);
        #1;
        check("writes outstanding", 24'h00_0000, 24'(expQ.size()));
        foreach (shadow[a]) begin
            check("memory word", 24'(shadow[a]), 24'(mem_u.memArr[a[12:1]]));
        end
        conclude();
    end
endmodule
